// *** hw/mgmt_addr_gen.sv ***
// Real-mode-like linear address generation for management mode
`timescale 1ns/100ps
`default_nettype none
module mgmt_addr_gen
  import mgmt_mode_pkg::*;
(
  // Operands
  input wire logic [15:0] selector,
  input wire logic [31:0] offset,
  input wire logic addr32_override,
  // Result
  output logic [31:0] linear
);
  logic [31:0] seg_base;
  logic [31:0] eff_ofs;
  // Selector shifted by four, offset cut to 16 bits unless overridden
  always_comb begin
    seg_base = {12'h000, selector, 4'h0};
    eff_ofs = addr32_override ? offset : {16'h0000, offset[15:0]};
    linear = seg_base + eff_ofs;
  end
endmodule // mgmt_addr_gen
`default_nettype wire

// *** hw/mgmt_entry_unit.sv ***
// Processor end: management-mode entry, state save, restore and base
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - Interrupt saves state into management memory first
// - Entry blocks interrupts and exceptions to OS
// - Resume restores saved state, leaves mode
// - Flat real-like addressing reaches 4 Gbytes
// - Space 64 Kbytes default, 32K to 4G
// - System logic steers memory on entry/exit
// - Default code segment base 30000h, selector 3000h
// - System backs whole upper 32 Kbytes
// - Default save at 3FE00h, handler at 38000h
// - Reset loads base register with 30000h
// - Revision identifier bit 17 reads one
// - Base changes only via save-area image
// - Save at base+FE00h, fetch base+8000h
// - Relocated base persists until changed or reset
// - 16-bit sizes, selector shifted four bits
// - Without override, addresses stop at 10FFEFh
// - Software keeps relocated base below 4G
// - Save area is 512 bytes FE00h-FFFFh
// - Handlers avoid writing read-only save entries
// - 16-byte segment blocks at FE00h/FE10h/FE20h
// - Restart entries are one byte each
// - Page-fault address register never saved/restored
module mgmt_entry_unit
  import mgmt_mode_pkg::*;
(
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Link to system logic
  mgmt_link_if.dev link,
  // Live segment state: extra, code, stack
  input wire logic [2:0][15:0] seg_selector,
  input wire logic [2:0][15:0] seg_attr,
  input wire logic [2:0][31:0] seg_limit,
  input wire logic [2:0][63:0] seg_base,
  input wire logic [7:0] io_restart,
  input wire logic [7:0] auto_halt,
  // Instruction events
  input wire logic resume_instr,
  // Address generation request
  input wire logic [15:0] agen_selector,
  input wire logic [31:0] agen_offset,
  input wire logic agen_override,
  // Mode and entry status
  output logic in_mgmt,
  output logic intr_block,
  output logic size16,
  output logic [31:0] mgmt_base,
  output logic handler_go,
  output logic [31:0] handler_ip,
  output logic [15:0] handler_cs_sel,
  output logic [31:0] handler_cs_base,
  // Restored state
  output logic restore_valid,
  output logic [2:0][15:0] rst_selector,
  output logic [2:0][15:0] rst_attr,
  output logic [2:0][31:0] rst_limit,
  output logic [2:0][63:0] rst_base,
  // Linear address
  output logic [31:0] agen_linear
);
  typedef enum logic [2:0] {D_IDLE, D_SAVE, D_RUN, D_RESTORE, D_EXIT} dev_state_e;
  typedef struct packed {
    dev_state_e st;
    logic [3:0] idx;
    logic [31:0] base;
    logic [31:0] base_img;
    logic req;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic in_mgmt;
    logic intr_block;
    logic handler_go;
    logic [31:0] handler_ip;
    logic [15:0] cs_sel;
    logic [31:0] cs_base;
    logic restore_valid;
    logic [2:0][15:0] r_sel;
    logic [2:0][15:0] r_attr;
    logic [2:0][31:0] r_lim;
    logic [2:0][63:0] r_base;
    logic [31:0] lin;
  } dev_s;

  dev_s r_reg, r_next;
  logic [31:0] lin_comb;
  logic [31:0] save_word;
  logic [1:0] seg;

  // Save-area offset of each transfer word, shared by save and restore
  function automatic logic [15:0] word_offset(input logic [3:0] i);
    logic [15:0] blk;
    blk = SAVED_EXTRA_SEG_SELECTOR_OFS + SEG_BLOCK_STRIDE * {12'h000, 2'b00, i[3:2]};
    case (i)
      4'hC: word_offset = RESTART_BYTES_OFS;
      4'hD: word_offset = REVISION_ID_OFS;
      4'hE: word_offset = BASE_IMAGE_OFS;
      default: begin
        case (i[1:0])
          2'h0: word_offset = blk;
          2'h1: word_offset = blk + (SAVED_EXTRA_SEG_LIMIT_OFS - SAVED_EXTRA_SEG_SELECTOR_OFS);
          2'h2: word_offset = blk + (SAVED_EXTRA_SEG_BASE_OFS - SAVED_EXTRA_SEG_SELECTOR_OFS);
          default: word_offset = blk + (SAVED_EXTRA_SEG_BASE_OFS - SAVED_EXTRA_SEG_SELECTOR_OFS)
                                 + 16'h0004;
        endcase
      end
    endcase
  endfunction

  // Real-mode-like address generation
  mgmt_addr_gen u_agen (
    .selector(agen_selector),
    .offset(agen_offset),
    .addr32_override(agen_override),
    .linear(lin_comb)
  );

  // ----------------------------------------------------------------
  // Word written at each save step
  // ----------------------------------------------------------------
  always_comb begin
    seg = r_reg.idx[3:2];
    save_word = 32'h0000_0000;
    case (r_reg.idx)
      4'hC: save_word = {16'h0000, auto_halt, io_restart};
      4'hD: save_word = REVISION_ID;
      4'hE: save_word = r_reg.base;
      default: begin
        case (r_reg.idx[1:0])
          2'h0: save_word = {seg_attr[seg], seg_selector[seg]};
          2'h1: save_word = seg_limit[seg];
          2'h2: save_word = seg_base[seg][31:0];
          default: save_word = seg_base[seg][63:32];
        endcase
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Entry and exit sequencing
  // ----------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    r_next.handler_go = 1'b0;
    r_next.restore_valid = 1'b0;
    r_next.lin = lin_comb;
    case (r_reg.st)
      D_IDLE: begin
        if (link.smi_req) begin
          r_next.st = D_SAVE;
          r_next.idx = 4'h0;
          r_next.in_mgmt = 1'b1;
          r_next.intr_block = 1'b1;
        end
      end
      D_SAVE: begin
        // Page-fault address register is not part of the transfer
        if (!r_reg.req) begin
          r_next.req = 1'b1;
          r_next.we = 1'b1;
          r_next.addr = r_reg.base + {16'h0000, word_offset(r_reg.idx)};
          r_next.wdata = save_word;
        end else if (link.ack) begin
          r_next.req = 1'b0;
          r_next.idx = r_reg.idx + 4'h1;
          if (r_reg.idx == LAST_WORD) begin
            r_next.st = D_RUN;
            r_next.handler_go = 1'b1;
            r_next.handler_ip = r_reg.base + HANDLER_ENTRY_OFS;
            r_next.cs_sel = r_reg.base[19:4];
            r_next.cs_base = r_reg.base;
          end
        end
      end
      D_RUN: begin
        if (resume_instr) begin
          r_next.st = D_RESTORE;
          r_next.idx = 4'h0;
        end
      end
      D_RESTORE: begin
        if (!r_reg.req) begin
          r_next.req = 1'b1;
          r_next.we = 1'b0;
          r_next.addr = r_reg.base + {16'h0000, word_offset(r_reg.idx)};
        end else if (link.ack) begin
          r_next.req = 1'b0;
          r_next.idx = r_reg.idx + 4'h1;
          if (r_reg.idx < SEG_WORDS) begin
            case (r_reg.idx[1:0])
              2'h0: begin
                r_next.r_sel[seg] = link.rdata[15:0];
                r_next.r_attr[seg] = link.rdata[31:16];
              end
              2'h1: r_next.r_lim[seg] = link.rdata;
              2'h2: r_next.r_base[seg][31:0] = link.rdata;
              default: r_next.r_base[seg][63:32] = link.rdata;
            endcase
          end else if (r_reg.idx == LAST_WORD) begin
            r_next.base_img = link.rdata;
            r_next.st = D_EXIT;
          end
        end
      end
      D_EXIT: begin
        r_next.base = r_reg.base_img;
        r_next.in_mgmt = 1'b0;
        r_next.intr_block = 1'b0;
        r_next.restore_valid = 1'b1;
        r_next.st = D_IDLE;
      end
      default: r_next.st = D_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_reg <= '0;
      r_reg.base <= MGMT_BASE_RESET;
      r_reg.base_img <= MGMT_BASE_RESET;
      r_reg.cs_sel <= MGMT_CS_SEL_DEFAULT;
      r_reg.cs_base <= MGMT_BASE_RESET;
    end else if (ce) begin
      r_reg <= r_next;
    end
  end

  // Outputs straight from the state register
  assign link.in_mgmt = r_reg.in_mgmt;
  assign link.req = r_reg.req;
  assign link.we = r_reg.we;
  assign link.addr = r_reg.addr;
  assign link.wdata = r_reg.wdata;
  assign in_mgmt = r_reg.in_mgmt;
  assign intr_block = r_reg.intr_block;
  assign size16 = r_reg.in_mgmt;
  assign mgmt_base = r_reg.base;
  assign handler_go = r_reg.handler_go;
  assign handler_ip = r_reg.handler_ip;
  assign handler_cs_sel = r_reg.cs_sel;
  assign handler_cs_base = r_reg.cs_base;
  assign restore_valid = r_reg.restore_valid;
  assign rst_selector = r_reg.r_sel;
  assign rst_attr = r_reg.r_attr;
  assign rst_limit = r_reg.r_lim;
  assign rst_base = r_reg.r_base;
  assign agen_linear = r_reg.lin;
endmodule // mgmt_entry_unit
`default_nettype wire

// *** hw/mgmt_sys_logic.sv ***
// System logic end: steers memory to management RAM, AXI4-Lite control
`timescale 1ns/100ps
`default_nettype none
module mgmt_sys_logic
  import mgmt_mode_pkg::*;
(
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Link to the processor
  mgmt_link_if.sys link,
  // Interrupt source
  input wire logic smi_trigger,
  // Main memory port
  output logic main_req,
  output logic main_we,
  output logic [31:0] main_addr,
  output logic [31:0] main_wdata,
  input wire logic main_ack,
  input wire logic [31:0] main_rdata,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  typedef enum logic [0:0] {S_IDLE, S_MAIN} sys_state_e;
  typedef struct packed {
    sys_state_e st;
    logic ack;
    logic [31:0] rdata;
    logic smi_req;
    logic main_req;
    logic main_we;
    logic [31:0] main_addr;
    logic [31:0] main_wdata;
    logic map_open;
    logic [31:0] win_base;
    logic awready;
    logic wready;
    logic aw_have;
    logic w_have;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] axi_rdata;
  } sys_s;

  sys_s r_reg, r_next;
  logic [31:0] ram [BACKED_WORDS];
  logic ram_we;
  logic [BACKED_IDX_W-1:0] ram_idx;
  logic [31:0] rel;
  logic hit;

  // Byte-lane merge of a register write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) m[8*b +: 8] = nw[8*b +: 8];
    end
    return m;
  endfunction

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    ram_we = 1'b0;
    rel = link.addr - r_reg.win_base;
    ram_idx = rel[BACKED_IDX_W+1:2];
    // Backed upper half of the space, in mode or while mapped open
    hit = (link.in_mgmt || r_reg.map_open) && rel >= BACKED_LOW_OFS
          && rel < SPACE_DEFAULT_BYTES[31:0];
    r_next.ack = 1'b0;
    // Interrupt request held until the processor shows entry
    if (smi_trigger) r_next.smi_req = 1'b1;
    else if (link.in_mgmt) r_next.smi_req = 1'b0;
    // Transaction steering
    case (r_reg.st)
      S_IDLE: begin
        if (link.req && !r_reg.ack) begin
          if (hit) begin
            r_next.ack = 1'b1;
            r_next.rdata = ram[ram_idx];
            ram_we = link.we;
          end else begin
            r_next.st = S_MAIN;
            r_next.main_req = 1'b1;
            r_next.main_we = link.we;
            r_next.main_addr = link.addr;
            r_next.main_wdata = link.wdata;
          end
        end
      end
      S_MAIN: begin
        if (main_ack) begin
          r_next.main_req = 1'b0;
          r_next.ack = 1'b1;
          r_next.rdata = main_rdata;
          r_next.st = S_IDLE;
        end
      end
      default: r_next.st = S_IDLE;
    endcase
    // AXI write address and data, either order
    if (s_axi_awvalid && r_reg.awready) begin
      r_next.awready = 1'b0;
      r_next.aw_have = 1'b1;
      r_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && r_reg.wready) begin
      r_next.wready = 1'b0;
      r_next.w_have = 1'b1;
      r_next.w_data = s_axi_wdata;
      r_next.w_strb = s_axi_wstrb;
    end
    if (r_reg.aw_have && r_reg.w_have && !r_reg.bvalid) begin
      r_next.aw_have = 1'b0;
      r_next.w_have = 1'b0;
      r_next.bvalid = 1'b1;
      r_next.bresp = RESP_OKAY;
      case (r_reg.aw_addr)
        SYS_CTRL_OFS: r_next.map_open = r_reg.w_strb[0] ? r_reg.w_data[CTRL_MAP_BIT]
                                                      : r_reg.map_open;
        SYS_WINDOW_OFS: r_next.win_base = merge(r_reg.win_base, r_reg.w_data, r_reg.w_strb);
        SYS_STATUS_OFS: r_next.bresp = RESP_OKAY;
        default: r_next.bresp = RESP_SLVERR;
      endcase
    end
    if (r_reg.bvalid && s_axi_bready) begin
      r_next.bvalid = 1'b0;
      r_next.awready = 1'b1;
      r_next.wready = 1'b1;
    end
    // AXI read
    if (s_axi_arvalid && r_reg.arready) begin
      r_next.arready = 1'b0;
      r_next.rvalid = 1'b1;
      r_next.rresp = RESP_OKAY;
      r_next.axi_rdata = 32'h0000_0000;
      case (s_axi_araddr)
        SYS_CTRL_OFS: r_next.axi_rdata[CTRL_MAP_BIT] = r_reg.map_open;
        SYS_STATUS_OFS: begin
          r_next.axi_rdata[STAT_MGMT_BIT] = link.in_mgmt;
          r_next.axi_rdata[STAT_SMI_BIT] = r_reg.smi_req;
        end
        SYS_WINDOW_OFS: r_next.axi_rdata = r_reg.win_base;
        default: r_next.rresp = RESP_SLVERR;
      endcase
    end
    if (r_reg.rvalid && s_axi_rready) begin
      r_next.rvalid = 1'b0;
      r_next.arready = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_reg <= '0;
      r_reg.win_base <= MGMT_BASE_RESET;
      r_reg.awready <= 1'b1;
      r_reg.wready <= 1'b1;
      r_reg.arready <= 1'b1;
    end else if (ce) begin
      r_reg <= r_next;
    end
  end

  // Backing RAM write port
  always_ff @(posedge aclk) begin
    if (ce && ram_we) ram[ram_idx] <= link.wdata;
  end

  // Outputs straight from the state register
  assign link.smi_req = r_reg.smi_req;
  assign link.ack = r_reg.ack;
  assign link.rdata = r_reg.rdata;
  assign main_req = r_reg.main_req;
  assign main_we = r_reg.main_we;
  assign main_addr = r_reg.main_addr;
  assign main_wdata = r_reg.main_wdata;
  assign s_axi_awready = r_reg.awready;
  assign s_axi_wready = r_reg.wready;
  assign s_axi_bvalid = r_reg.bvalid;
  assign s_axi_bresp = r_reg.bresp;
  assign s_axi_arready = r_reg.arready;
  assign s_axi_rvalid = r_reg.rvalid;
  assign s_axi_rresp = r_reg.rresp;
  assign s_axi_rdata = r_reg.axi_rdata;
endmodule // mgmt_sys_logic
`default_nettype wire

// *** pkg/mgmt_link_if.sv ***
// Link between the processor end and the system logic end
`timescale 1ns/100ps
`default_nettype none
interface mgmt_link_if;
  logic smi_req;
  logic in_mgmt;
  logic req;
  logic we;
  logic [31:0] addr;
  logic [31:0] wdata;
  logic ack;
  logic [31:0] rdata;
  // Processor end
  modport dev (input smi_req, input ack, input rdata,
               output in_mgmt, output req, output we, output addr, output wdata);
  // System logic end
  modport sys (output smi_req, output ack, output rdata,
               input in_mgmt, input req, input we, input addr, input wdata);
endinterface
`default_nettype wire

// *** pkg/mgmt_mode_pkg.sv ***
// Shared constants for the management-mode entry unit and its system logic
package mgmt_mode_pkg;
  // ----------------------------------------------------------------
  // Management memory space and base register
  // ----------------------------------------------------------------
  localparam logic [31:0] MGMT_BASE_RESET = 32'h0003_0000;
  localparam logic [15:0] MGMT_CS_SEL_DEFAULT = 16'h3000;
  localparam logic [31:0] HANDLER_ENTRY_OFS = 32'h0000_8000;
  localparam logic [31:0] SAVE_AREA_OFS = 32'h0000_FE00;
  localparam logic [31:0] SAVE_AREA_END_OFS = 32'h0000_FFFF;
  localparam logic [31:0] SAVE_AREA_BYTES = 32'h0000_0200;
  localparam logic [32:0] SPACE_DEFAULT_BYTES = 33'h0_0001_0000;
  localparam logic [32:0] SPACE_MIN_BYTES = 33'h0_0000_8000;
  localparam logic [32:0] SPACE_MAX_BYTES = 33'h1_0000_0000;
  localparam logic [31:0] BACKED_LOW_OFS = 32'h0000_8000;
  localparam int BACKED_WORDS = 8192;
  localparam int BACKED_IDX_W = 13;
  // ----------------------------------------------------------------
  // Save-area layout
  // ----------------------------------------------------------------
  localparam logic [15:0] SAVED_EXTRA_SEG_SELECTOR_OFS = 16'hFE00;
  localparam logic [15:0] SAVED_EXTRA_SEG_ATTRIBUTES_OFS = 16'hFE02;
  localparam logic [15:0] SAVED_EXTRA_SEG_LIMIT_OFS = 16'hFE04;
  localparam logic [15:0] SAVED_EXTRA_SEG_BASE_OFS = 16'hFE08;
  localparam logic [15:0] SAVED_CODE_SEG_SELECTOR_OFS = 16'hFE10;
  localparam logic [15:0] SAVED_CODE_SEG_ATTRIBUTES_OFS = 16'hFE12;
  localparam logic [15:0] SAVED_CODE_SEG_LIMIT_OFS = 16'hFE14;
  localparam logic [15:0] SAVED_CODE_SEG_BASE_OFS = 16'hFE18;
  localparam logic [15:0] SAVED_STACK_SEG_SELECTOR_OFS = 16'hFE20;
  localparam logic [15:0] SAVED_STACK_SEG_ATTRIBUTES_OFS = 16'hFE22;
  localparam logic [15:0] SAVED_STACK_SEG_LIMIT_OFS = 16'hFE24;
  localparam logic [15:0] SAVED_STACK_SEG_BASE_OFS = 16'hFE28;
  localparam logic [15:0] SEG_BLOCK_STRIDE = 16'h0010;
  localparam logic [15:0] RESTART_BYTES_OFS = 16'hFEC8;
  localparam logic [15:0] REVISION_ID_OFS = 16'hFEFC;
  localparam logic [15:0] BASE_IMAGE_OFS = 16'hFF00;
  localparam int RELOC_BIT = 17;
  localparam logic [31:0] REVISION_ID = 32'h0002_0000;
  localparam logic [3:0] SEG_WORDS = 4'hC;
  localparam logic [3:0] LAST_WORD = 4'hE;
  // ----------------------------------------------------------------
  // Address generation
  // ----------------------------------------------------------------
  localparam logic [31:0] ADDR16_MAX = 32'h0010_FFEF;
  // ----------------------------------------------------------------
  // System logic registers on AXI4-Lite
  // ----------------------------------------------------------------
  localparam logic [7:0] SYS_CTRL_OFS = 8'h00;
  localparam logic [7:0] SYS_STATUS_OFS = 8'h04;
  localparam logic [7:0] SYS_WINDOW_OFS = 8'h08;
  localparam int CTRL_MAP_BIT = 0;
  localparam int STAT_MGMT_BIT = 0;
  localparam int STAT_SMI_BIT = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** verif/mgmt_link_chk.sv ***
// Concurrent checks on the link between the two ends
`timescale 1ns/100ps
`default_nettype none
module mgmt_link_chk (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Link signals
  input wire logic smi_req,
  input wire logic in_mgmt,
  input wire logic req,
  input wire logic we,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire logic ack,
  input wire logic [31:0] rdata
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Save steps: first segment word, then the next word three cycles on
  sequence s_first_save;
    req && we && addr[15:0] == 16'hFE00;
  endsequence
  sequence s_second_save;
    ##3 req && we && addr[15:0] == 16'hFE04;
  endsequence
  a_req_held:
    assert property (req && !ack |=> req && $stable(addr) && $stable(we))
    else $error("request changed before ack");
  a_idle_gap:
    assert property (ack |=> !req) else $error("no idle cycle after ack");
  a_ack_pulse:
    assert property (ack |=> !ack) else $error("ack longer than one cycle");
  a_smi_entry:
    assert property (smi_req && !in_mgmt |-> ##[1:2] in_mgmt) else $error("no entry on request");
  a_first_save:
    assert property ($rose(in_mgmt) |=> s_first_save) else $error("first save not at FE00");
  a_word_order:
    assert property (s_first_save |-> s_second_save) else $error("second word not at FE04");
  a_save_area:
    assert property (req |-> addr[15:9] == 7'h7F) else $error("access outside save area");
  a_mode_access:
    assert property (req |-> in_mgmt) else $error("transfer outside management mode");
  a_reloc_bit:
    assert property (req && we && addr[15:0] == 16'hFEFC |-> wdata[17])
    else $error("relocation bit not set");
  a_restart_byte:
    assert property (req && we && addr[15:0] == 16'hFEC8 |-> wdata[31:16] == 16'h0000)
    else $error("restart field too wide");
endmodule // mgmt_link_chk
`default_nettype wire

// *** verif/smm_entry_state_save_tb_top.sv ***
// Testbench joining the processor end and the system logic end
`timescale 1ns/100ps
`default_nettype none
module smm_entry_state_save_tb_top;
  import mgmt_mode_pkg::*;
  logic aclk, aresetn, ce, smi_trigger, resume_instr, agen_override;
  logic main_req, main_we, main_ack, in_mgmt, intr_block, size16, handler_go, restore_valid;
  logic [31:0] main_addr, main_wdata, main_rdata, agen_offset, agen_linear, mgmt_base;
  logic [31:0] handler_ip, handler_cs_base, s_axi_wdata, s_axi_rdata;
  logic [15:0] agen_selector, handler_cs_sel;
  logic [2:0][15:0] seg_selector, seg_attr, rst_selector, rst_attr;
  logic [2:0][31:0] seg_limit, rst_limit;
  logic [2:0][63:0] seg_base, rst_base;
  logic [7:0] io_restart, auto_halt, s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [31:0] d;
  int num_errors = 0;
  int n_checks = 0;
  mgmt_link_if link ();
  mgmt_entry_unit mgmt_entry_unit_inst (.aclk, .aresetn, .ce, .link(link), .seg_selector,
    .seg_attr, .seg_limit, .seg_base, .io_restart, .auto_halt, .resume_instr, .agen_selector,
    .agen_offset, .agen_override, .in_mgmt, .intr_block, .size16, .mgmt_base, .handler_go,
    .handler_ip, .handler_cs_sel, .handler_cs_base, .restore_valid, .rst_selector, .rst_attr,
    .rst_limit, .rst_base, .agen_linear);
  mgmt_sys_logic mgmt_sys_logic_inst (.aclk, .aresetn, .ce, .link(link), .smi_trigger,
    .main_req, .main_we, .main_addr, .main_wdata, .main_ack, .main_rdata, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  mgmt_link_chk mgmt_link_chk_inst (.aclk, .aresetn, .smi_req(link.smi_req),
    .in_mgmt(link.in_mgmt), .req(link.req), .we(link.we), .addr(link.addr),
    .wdata(link.wdata), .ack(link.ack), .rdata(link.rdata));
  // Clock and main memory responder
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    main_ack <= main_req && !main_ack;
    main_rdata <= ~main_addr;
  end
  // -----------------------------------------------------------
  // Shared tasks
  // -----------------------------------------------------------
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (aw && s_axi_awready) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end while (aw || w);
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic axi_rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic set_seg(input logic [7:0] k);
    for (int i = 0; i < 3; i++) begin
      seg_selector[i] <= {k, 8'(i)};
      seg_attr[i] <= {8'(i), k};
      seg_limit[i] <= {4{k}};
      seg_base[i] <= {k, 48'h0, 8'(i)};
    end
  endtask
  // One entry, live state changed in the handler, then resume
  task automatic enter_exit(input logic [7:0] k);
    set_seg(k);
    smi_trigger <= 1'b1;
    @(posedge aclk);
    smi_trigger <= 1'b0;
    for (int i = 0; i < 400 && handler_go !== 1'b1; i++) @(posedge aclk);
    chk("handler_go", 1'b1, handler_go);
    chk("handler_ip", 32'h0003_8000, handler_ip);
    chk("intr_block", 1'b1, intr_block);
    chk("size16", 1'b1, size16);
    set_seg(~k);
    axi_rd(SYS_STATUS_OFS);
    chk("status_mode", 1'b1, d[STAT_MGMT_BIT]);
    chk("main_req", 1'b0, main_req);
    resume_instr <= 1'b1;
    @(posedge aclk);
    resume_instr <= 1'b0;
    for (int i = 0; i < 400 && restore_valid !== 1'b1; i++) @(posedge aclk);
    chk("restore_valid", 1'b1, restore_valid);
    for (int i = 0; i < 3; i++) begin
      chk("rst_selector", {k, 8'(i)}, rst_selector[i]);
      chk("rst_attr", {8'(i), k}, rst_attr[i]);
      chk("rst_limit", {4{k}}, rst_limit[i]);
      chk("rst_base", {k, 48'h0, 8'(i)}, rst_base[i]);
    end
    chk("in_mgmt_exit", 1'b0, in_mgmt);
    chk("intr_block_exit", 1'b0, intr_block);
    chk("mgmt_base", MGMT_BASE_RESET, mgmt_base);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // -----------------------------------------------------------
  // Test sequence
  // -----------------------------------------------------------
  initial begin
    {aresetn, smi_trigger, resume_instr, agen_override} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, agen_selector, agen_offset} = '0;
    {io_restart, auto_halt} = 16'hA55A;
    ce = 1'b1;
    s_axi_wstrb = 4'hF;
    set_seg(8'h00);
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("base_reset", 32'h0003_0000, mgmt_base);
    chk("cs_sel", 16'h3000, handler_cs_sel);
    chk("cs_base", 32'h0003_0000, handler_cs_base);
    axi_rd(SYS_WINDOW_OFS);
    chk("window", 32'h0003_0000, d);
    axi_wr(8'h0C, 32'h1);
    chk("wr_unmapped", RESP_SLVERR, r);
    axi_rd(8'h0C);
    chk("rd_unmapped", RESP_SLVERR, r);
    enter_exit(8'h5C);
    enter_exit(8'hC3);
    agen_selector <= 16'hFFFF;
    agen_offset <= 32'h0001_FFFF;
    repeat (2) @(posedge aclk);
    chk("agen16", 32'h0010_FFEF, agen_linear);
    agen_selector <= 16'h0001;
    agen_offset <= 32'hF000_0000;
    agen_override <= 1'b1;
    repeat (2) @(posedge aclk);
    chk("agen32", 32'hF000_0010, agen_linear);
    print_verdict();
  end
  // Watchdog against a hang
  initial begin
    #40000;
    num_errors++;
    print_verdict();
  end
endmodule // smm_entry_state_save_tb_top
`default_nettype wire
